/* mlpc_pkg.sv */
// Shared constants, command codes and decoders for the mission log and password control block.
// Assumes one 40 MHz clock domain shared by the device end and the controller end.
package mlpc_pkg;
    localparam int          CNT_W          = 24;
    localparam logic [23:0] CNT_MAX        = 24'hFFFFFF;
    localparam int          ADDR_W         = 10;
    localparam int          PW_W           = 64;
    localparam logic [6:0]  PW_LAST        = 7'h3F;
    localparam logic [7:0]  PW_ENABLE      = 8'hAA;
    // Arbitrary value; it only stands in for a product variant code.
    localparam logic [7:0]  VARIANT_CODE   = 8'h5A;

    localparam logic [9:0]  OFS_MISSION    = 10'h220;
    localparam logic [9:0]  OFS_LIFETIME   = 10'h223;
    localparam logic [9:0]  OFS_VARIANT    = 10'h226;
    localparam logic [9:0]  OFS_PWCTL      = 10'h227;
    localparam logic [9:0]  OFS_READ_PW    = 10'h228;
    localparam logic [9:0]  OFS_FULL_PW    = 10'h230;
    localparam logic [4:0]  REG_PAGE       = 5'h11;
    localparam logic [2:0]  PWCTL_SLOT     = 3'h7;
    localparam logic [1:0]  RDPW_SLOT      = 2'h1;
    localparam logic [1:0]  FULLPW_SLOT    = 2'h2;

    localparam int          LOG_AW         = 13;
    localparam logic [13:0] ENT_ONE_BYTE   = 14'h2000;
    localparam logic [13:0] ENT_ONE_WORD   = 14'h1000;
    localparam logic [13:0] ENT_TWO_BYTE   = 14'h1000;
    localparam logic [13:0] ENT_TWO_WORD   = 14'h0800;
    localparam logic [13:0] ENT_MIXED      = 14'h0A00;

    localparam logic [3:0]  WB_CMD         = 4'h0;
    localparam logic [3:0]  WB_PW_LO       = 4'h4;
    localparam logic [3:0]  WB_PW_HI       = 4'h8;
    localparam logic [3:0]  WB_STATUS      = 4'hC;

    typedef enum logic [2:0] {
        CMD_WR_SCRATCH = 3'h0,
        CMD_RD_SCRATCH = 3'h1,
        CMD_FORCE_CONV = 3'h2,
        CMD_READ_CRC   = 3'h3,
        CMD_COPY       = 3'h4,
        CMD_CLEAR      = 3'h5,
        CMD_START      = 3'h6,
        CMD_STOP       = 3'h7
    } mlpc_cmd_t;

    // Every command from read-with-check upward carries a 64-bit password.
    function automatic logic needs_pw(input mlpc_cmd_t c);
        return c >= CMD_READ_CRC;
    endfunction
endpackage

/* mlpc_link_if.sv */
// Command link between the controller end and the device end.
// Both ends run on the same clock; the bench joins them through this interface.
`timescale 1ns/1ps
`default_nettype none
interface mlpc_link_if;
    mlpc_pkg::mlpc_cmd_t cmd_code;
    logic                cmd_valid;
    logic [9:0]          addr;
    logic [7:0]          wdata;
    logic                pw_valid;
    logic                pw_bit;
    logic                done;
    logic                ok;
    logic [7:0]          rdata;

    modport master (output cmd_code, cmd_valid, addr, wdata, pw_valid, pw_bit,
                    input  done, ok, rdata);
    modport target (input  cmd_code, cmd_valid, addr, wdata, pw_valid, pw_bit,
                    output done, ok, rdata);
endinterface
`default_nettype wire

/* mlpc_device.sv */
// Device end: sample counters, log addressing, password registers and command execution.
// Assumes the wake, delay and alarm inputs come from same-clock mission timing logic.
// Behaviour
// R01: Mission counter counts measuring wake-ups in mission.
// R02: Alarm-start mode skips counting the first sample.
// R03: Dual-channel wake-up counts once per counter.
// R04: Clear command zeroes the mission counter.
// R05: Lifetime counter counts logs and alarm tests.
// R06: Outside missions, forced conversion bumps lifetime counter.
// R07: Lifetime counter is 24-bit, read only.
// R08: Read-only variant byte identifies the product.
// R09: Scratchpad and forced conversion need no password.
// R10: Master sends password right after command.
// R11: Checking enabled only by pattern AA.
// R12: Checking off accepts any full 64 bits.
// R13: Enabled checking demands full password for changes.
// R14: Passwords write-only, read back as zeros.
// R15: No password or control change during mission.
// R16: Read password guards only read-with-check.
// R17: Full password guards five protected commands.
// R18: Master writes control and passwords together.
// R19: Log splits 8192/4096/2048 by channels, format.
// R20: Mixed formats give each channel 2560 entries.
// R21: Upper byte of 16-bit entry at lower address.
// R22: Full section stops or wraps to its start.
// R23: Alarm testing waits for start delay expiry.
// R24: Wrap disabled never overwrites logged data.
`timescale 1ns/1ps
`default_nettype none
module mlpc_device (
    input  wire logic              clk_i,                 // 40 MHz clock
    input  wire logic              rst_i,                 // Synchronous reset, active high
    mlpc_link_if.target            link,                  // Command link from the controller
    input  wire logic              start_on_temp_alarm_i, // Mission starts on temperature alarm
    input  wire logic              temp_log_enable_i,     // Log temperature
    input  wire logic              humid_log_enable_i,    // Log humidity
    input  wire logic              temp_wide_i,           // Temperature entries are 16-bit
    input  wire logic              humid_wide_i,          // Humidity entries are 16-bit
    input  wire logic              log_wrap_enable_i,     // Overwrite oldest entries when full
    input  wire logic              wake_i,                // Sample-interval wake-up pulse
    input  wire logic              delay_done_i,          // Mission start delay has expired
    input  wire logic              alarm_hit_i,           // Temperature alarm seen at this wake-up
    input  wire logic [15:0]       temp_sample_i,         // Temperature reading
    input  wire logic [15:0]       humid_sample_i,        // Humidity reading
    output logic                   mission_active_o,      // Mission in progress
    output logic                   mem_cleared_o,         // Memory cleared, mission may start
    output logic                   waiting_alarm_o,       // Waiting for the starting alarm
    output logic [23:0]            mission_sample_count_o,  // Mission sample counter
    output logic [23:0]            lifetime_sample_count_o, // Lifetime sample counter
    output logic [1:0]             log_we_o,              // Log write strobe per channel
    output logic [1:0][12:0]       log_addr_o,            // Entry byte address per channel
    output logic [1:0][15:0]       log_data_o             // Entry data per channel
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PW   = 2'b01,
        ST_EXEC = 2'b11
    } mlpc_dev_state_t;

    mlpc_dev_state_t     state;
    mlpc_pkg::mlpc_cmd_t cmd;
    logic [9:0]          cmd_addr;
    logic [7:0]          cmd_wdata;
    logic [63:0]         pw_shift;
    logic [6:0]          pw_cnt;
    logic [7:0]          scratch [32];
    logic [4:0]          scratch_page;
    logic [7:0]          password_check_control;
    logic [63:0]         read_password;
    logic [63:0]         full_password;
    logic [23:0]         mission_sample_count;
    logic [23:0]         lifetime_sample_count;
    logic                mission_active;
    logic                mem_cleared;
    logic                waiting_alarm;
    logic                done;
    logic                ok;
    logic [7:0]          rdata;

    function automatic logic [13:0] sec_len(input logic other_on, input logic own_w, input logic other_w);
        if (!other_on)
            return own_w ? mlpc_pkg::ENT_ONE_WORD : mlpc_pkg::ENT_ONE_BYTE;
        if (own_w != other_w)
            return mlpc_pkg::ENT_MIXED;
        return own_w ? mlpc_pkg::ENT_TWO_WORD : mlpc_pkg::ENT_TWO_BYTE;
    endfunction

    wire checking  = password_check_control == mlpc_pkg::PW_ENABLE;                      // R11
    wire full_ok   = !checking || (pw_shift == full_password);                           // R12 R17
    wire read_ok   = full_ok || (pw_shift == read_password);                             // R16
    wire auth      = !mlpc_pkg::needs_pw(cmd) || ((cmd == mlpc_pkg::CMD_READ_CRC) ? read_ok : full_ok); // R09
    wire pw_done   = link.pw_valid && (pw_cnt == mlpc_pkg::PW_LAST);                     // R12
    wire exec      = state == ST_EXEC;

    wire wake_test = wake_i && mission_active && waiting_alarm && delay_done_i;          // R23
    wire first_log = wake_test && alarm_hit_i;                                           // R02
    wire norm_log  = wake_i && mission_active && !waiting_alarm && delay_done_i;         // R01
    wire log_evt   = first_log || norm_log;
    wire force_cnt = exec && auth && (cmd == mlpc_pkg::CMD_FORCE_CONV) && !mission_active; // R06
    wire [1:0] lt_add = {1'b0, wake_test || norm_log} + {1'b0, force_cnt};               // R05 R03
    wire lt_sat    = lifetime_sample_count > (mlpc_pkg::CNT_MAX - {22'h0, lt_add});      // R07

    // Register page read: counters, variant, control; passwords and the rest read zero.
    wire [63:0] page_bytes = {password_check_control, mlpc_pkg::VARIANT_CODE,
                              lifetime_sample_count, mission_sample_count};              // R08
    wire        in_page    = cmd_addr[9:3] == mlpc_pkg::OFS_MISSION[9:3];
    wire [7:0]  reg_byte   = in_page ? page_bytes[{cmd_addr[2:0], 3'h0} +: 8] : 8'h00;  // R14

    wire copy_regs = exec && auth && (cmd == mlpc_pkg::CMD_COPY) && !mission_active
                     && (scratch_page == mlpc_pkg::REG_PAGE);                            // R13 R15
    wire start_ok  = !mission_active && mem_cleared && (temp_log_enable_i || humid_log_enable_i);
    wire cmd_ok    = auth && (((cmd == mlpc_pkg::CMD_COPY) && copy_regs)
                     || ((cmd == mlpc_pkg::CMD_START) && start_ok)
                     || ((cmd == mlpc_pkg::CMD_CLEAR) && !mission_active)
                     || ((cmd != mlpc_pkg::CMD_COPY) && (cmd != mlpc_pkg::CMD_START)
                         && (cmd != mlpc_pkg::CMD_CLEAR)));
    wire [7:0] next_rdata = (cmd == mlpc_pkg::CMD_RD_SCRATCH) ? scratch[cmd_addr[4:0]]
                          : (cmd == mlpc_pkg::CMD_READ_CRC && auth) ? reg_byte : 8'h00;   // R16

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state    <= ST_IDLE;
            pw_cnt   <= 7'h00;
            done     <= 1'b0;
        end
        else
        begin
            done <= exec;
            unique case (state)
                ST_IDLE:
                begin
                    pw_cnt <= 7'h00;
                    if (link.cmd_valid)
                        state <= mlpc_pkg::needs_pw(link.cmd_code) ? ST_PW : ST_EXEC; // R10
                end
                ST_PW:
                begin
                    // A new command mid-password aborts; fewer than 64 bits never executes.
                    if (link.cmd_valid)
                        state <= ST_IDLE;
                    else if (pw_done)
                        state <= ST_EXEC;
                    if (link.pw_valid)
                        pw_cnt <= pw_cnt + 7'h01;
                end
                ST_EXEC:
                    state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (state == ST_IDLE && link.cmd_valid)
        begin
            cmd       <= link.cmd_code;
            cmd_addr  <= link.addr;
            cmd_wdata <= link.wdata;
        end
        if (state == ST_PW && link.pw_valid)
            pw_shift <= {link.pw_bit, pw_shift[63:1]};                                   // R16 R17
        if (exec)
        begin
            ok    <= cmd_ok;
            rdata <= next_rdata;
        end
        if (exec && cmd == mlpc_pkg::CMD_WR_SCRATCH)
        begin
            scratch[cmd_addr[4:0]] <= cmd_wdata;
            scratch_page           <= cmd_addr[9:5];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            password_check_control <= 8'h00;
            read_password          <= 64'h0;
            full_password          <= 64'h0;
            mission_active         <= 1'b0;
            mem_cleared            <= 1'b0;
            waiting_alarm          <= 1'b0;
            mission_sample_count   <= 24'h0;
            lifetime_sample_count  <= 24'h0;
        end
        else
        begin
            if (copy_regs)
            begin
                password_check_control <= scratch[mlpc_pkg::PWCTL_SLOT];                  // R15
                for (int i = 0; i < 8; i++)
                begin
                    read_password[8*i +: 8] <= scratch[{mlpc_pkg::RDPW_SLOT, 3'(i)}];
                    full_password[8*i +: 8] <= scratch[{mlpc_pkg::FULLPW_SLOT, 3'(i)}];
                end
            end
            if (exec && auth && cmd == mlpc_pkg::CMD_CLEAR && !mission_active)
            begin
                mission_sample_count <= 24'h0;                                           // R04
                mem_cleared          <= 1'b1;
            end
            else if (norm_log)
                mission_sample_count <= mission_sample_count + 24'h1;                    // R01 R03
            if (exec && auth && cmd == mlpc_pkg::CMD_START && start_ok)
            begin
                mission_active <= 1'b1;
                mem_cleared    <= 1'b0;
                waiting_alarm  <= start_on_temp_alarm_i && temp_log_enable_i;
            end
            else if (first_log)
                waiting_alarm <= 1'b0;
            if (exec && auth && cmd == mlpc_pkg::CMD_STOP)
                mission_active <= 1'b0;
            lifetime_sample_count <= lt_sat ? mlpc_pkg::CNT_MAX
                                   : lifetime_sample_count + {22'h0, lt_add};            // R07
        end
    end

    wire [1:0]       ch_on   = {humid_log_enable_i, temp_log_enable_i};
    wire [1:0]       ch_wide = {humid_wide_i, temp_wide_i};
    wire [1:0][15:0] ch_data = {humid_sample_i, temp_sample_i};
    wire [13:0]      len0    = sec_len(ch_on[1], ch_wide[0], ch_wide[1]);                // R19 R20
    wire [13:0]      len1    = sec_len(ch_on[0], ch_wide[1], ch_wide[0]);
    wire [12:0]      base1   = ch_on[0] ? 13'(len0 << ch_wide[0]) : 13'h0;
    wire [1:0][13:0] ch_len  = {len1, len0};
    wire [1:0][12:0] ch_base = {base1, 13'h0};

    for (genvar c = 0; c < 2; c++)
    begin : g_chan
        logic [13:0] idx;
        logic        full;
        wire         last    = idx == ch_len[c] - 14'h1;
        wire         do_log  = log_evt && ch_on[c] && !full;                             // R24
        wire [12:0]  ent_ofs = 13'(idx << ch_wide[c]);

        always_ff @(posedge clk_i)
        begin
            if (rst_i || (exec && auth && cmd == mlpc_pkg::CMD_CLEAR && !mission_active))
            begin
                idx         <= 14'h0;
                full        <= 1'b0;
                log_we_o[c] <= 1'b0;
            end
            else
            begin
                log_we_o[c] <= do_log;
                if (do_log)
                begin
                    // The address names the upper byte of a 16-bit entry; the lower follows it.
                    log_addr_o[c] <= ch_base[c] + ent_ofs;                               // R21
                    log_data_o[c] <= ch_data[c];
                    idx           <= last ? 14'h0 : idx + 14'h1;                         // R22
                    full          <= last && !log_wrap_enable_i;                         // R22 R24
                end
            end
        end
    end

    assign link.done               = done;
    assign link.ok                 = ok;
    assign link.rdata              = rdata;
    assign mission_active_o        = mission_active;
    assign mem_cleared_o           = mem_cleared;
    assign waiting_alarm_o         = waiting_alarm;
    assign mission_sample_count_o  = mission_sample_count;
    assign lifetime_sample_count_o = lifetime_sample_count;
endmodule
`default_nettype wire

/* mlpc_host.sv */
// Controller end: a classic Wishbone slave whose command register drives the link as master.
// Assumes the device end answers every command with a one-cycle done pulse.
`timescale 1ns/1ps
`default_nettype none
module mlpc_host (
    input  wire logic        clk_i,   // 40 MHz clock
    input  wire logic        rst_i,   // Synchronous reset, active high
    input  wire logic        cyc_i,   // Wishbone cycle
    input  wire logic        stb_i,   // Wishbone strobe
    input  wire logic        we_i,    // Wishbone write enable
    input  wire logic [3:0]  adr_i,   // Wishbone byte address
    input  wire logic [3:0]  sel_i,   // Wishbone byte selects
    input  wire logic [31:0] dat_i,   // Wishbone write data
    output logic      [31:0] dat_o,   // Wishbone read data
    output logic             ack_o,   // Wishbone acknowledge
    mlpc_link_if.master      link     // Command link to the device
);
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_SEND = 2'b01,
        HS_PW   = 2'b11,
        HS_WAIT = 2'b10
    } mlpc_host_state_t;

    mlpc_host_state_t    state;
    mlpc_pkg::mlpc_cmd_t cmd;
    logic [9:0]          cmd_addr;
    logic [7:0]          cmd_wdata;
    logic [63:0]         pw;
    logic [63:0]         pw_tx;
    logic [6:0]          pw_cnt;
    logic                last_ok;
    logic [7:0]          last_rdata;
    logic                ack;
    logic [31:0]         rd;

    wire req     = cyc_i && stb_i && !ack;
    wire wr      = req && we_i && (sel_i == 4'hF);
    wire busy    = state != HS_IDLE;
    wire go      = wr && (adr_i == mlpc_pkg::WB_CMD) && !busy;
    wire [31:0] next_rd = (adr_i == mlpc_pkg::WB_PW_LO)  ? pw[31:0]
                        : (adr_i == mlpc_pkg::WB_PW_HI)  ? pw[63:32]
                        : (adr_i == mlpc_pkg::WB_STATUS) ? {16'h0, last_rdata, 6'h0, last_ok, busy}
                        : 32'h0;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack <= 1'b0;
            rd  <= 32'h0;
        end
        else
        begin
            ack <= req;
            rd  <= next_rd;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state      <= HS_IDLE;
            pw         <= 64'h0;
            pw_cnt     <= 7'h00;
            last_ok    <= 1'b0;
            last_rdata <= 8'h00;
        end
        else
        begin
            if (wr && adr_i == mlpc_pkg::WB_PW_LO)
                pw[31:0] <= dat_i;
            if (wr && adr_i == mlpc_pkg::WB_PW_HI)
                pw[63:32] <= dat_i;
            unique case (state)
                HS_IDLE:
                    if (go)
                    begin
                        cmd       <= mlpc_pkg::mlpc_cmd_t'(dat_i[2:0]);
                        cmd_wdata <= dat_i[15:8];
                        cmd_addr  <= dat_i[25:16];
                        state     <= HS_SEND;
                    end
                HS_SEND:
                begin
                    pw_tx  <= pw;
                    pw_cnt <= 7'h00;
                    state  <= mlpc_pkg::needs_pw(cmd) ? HS_PW : HS_WAIT;                 // R10
                end
                HS_PW:
                begin
                    pw_tx  <= {1'b0, pw_tx[63:1]};                                       // R16 R17
                    pw_cnt <= pw_cnt + 7'h01;
                    if (pw_cnt == mlpc_pkg::PW_LAST)
                        state <= HS_WAIT;
                end
                HS_WAIT:
                    if (link.done)
                    begin
                        last_ok    <= link.ok;
                        last_rdata <= link.rdata;
                        state      <= HS_IDLE;
                    end
            endcase
        end
    end

    assign link.cmd_valid = state == HS_SEND;
    assign link.cmd_code  = cmd;
    assign link.addr      = cmd_addr;
    assign link.wdata     = cmd_wdata;
    assign link.pw_valid  = state == HS_PW;
    assign link.pw_bit    = pw_tx[0];
    assign ack_o          = ack;
    assign dat_o          = rd;
endmodule
`default_nettype wire

/* mlpc_monitor.sv */
// Checker for the command link between the controller end and the device end.
// Assumes it sits beside the link interface and sees its signals as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module mlpc_monitor (
    input  wire logic                clk_i,     // Clock
    input  wire logic                rst_i,     // Synchronous reset
    input  wire mlpc_pkg::mlpc_cmd_t cmd_code,  // Command code
    input  wire logic                cmd_valid, // Command strobe
    input  wire logic                pw_valid,  // Password bit strobe
    input  wire logic                done,      // Command finished
    input  wire logic                ok,        // Command accepted
    input  wire logic [7:0]          rdata      // Read byte
);
    logic [6:0] pw_cnt;
    logic       armed;

    // Result outputs are unreset, so they are only watched once a command has finished.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || cmd_valid)
            pw_cnt <= 7'h00;
        else if (pw_valid)
            pw_cnt <= pw_cnt + 7'h01;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            armed <= 1'h0;
        else if (done)
            armed <= 1'h1;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_plain_cmd_done: assert property (cmd_valid && cmd_code < mlpc_pkg::CMD_READ_CRC |=> !done ##1 done)
        else $error("unguarded command not done in two cycles");
    a_pw_after_cmd: assert property (cmd_valid && cmd_code >= mlpc_pkg::CMD_READ_CRC |=> pw_valid)
        else $error("password does not follow guarded command");
    a_pw_count_max: assert property (pw_valid |-> pw_cnt < 7'h40)
        else $error("more than 64 password bits");
    a_pw_full_len: assert property ($fell(pw_valid) |-> pw_cnt == 7'h40)
        else $error("password not exactly 64 bits");
    a_done_after_pw: assert property ($fell(pw_valid) |=> done)
        else $error("guarded command not done after password");
    a_no_early_done: assert property (pw_valid |-> !done)
        else $error("command done while password arrives");
    a_ok_with_done: assert property (armed && $changed(ok) |-> done)
        else $error("result flag changed outside completion");
    a_rdata_with_done: assert property (armed && $changed(rdata) |-> done)
        else $error("read byte changed outside completion");
    a_done_one_cycle: assert property (done |=> !done)
        else $error("done longer than one cycle");

    cover property (cmd_valid && cmd_code == mlpc_pkg::CMD_START);
    cover property (done && !ok);
    cover property ($fell(pw_valid));
endmodule
`default_nettype wire

/* mlpc_test.sv */
// Bench: a classic Wishbone master orders commands through the controller end into the device end.
// Assumes ack one cycle after a request and a busy flag in the status register while a command runs.
`timescale 1ns/1ps
`default_nettype none
module mlpc_test;
    localparam logic [63:0] RPW = 64'h1122334455667788;
    localparam logic [63:0] FPW = 64'h99AABBCCDDEEFF01;
    localparam logic [63:0] BAD = 64'h0123456789ABCDEF;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc, stb, we, ack, sut, ten, hen, twide, wake, ddone, alarm, act, wta, mcl;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, st;
    logic [23:0] mcnt, lcnt;
    logic [1:0][12:0] laddr;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    mlpc_link_if link ();

    always #12.5 clk_i = ~clk_i;

    mlpc_host mlpc_host_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .link(link.master));
    mlpc_device mlpc_device_i (.clk_i(clk_i), .rst_i(rst_i), .link(link.target), .start_on_temp_alarm_i(sut),
        .temp_log_enable_i(ten), .humid_log_enable_i(hen), .temp_wide_i(twide), .humid_wide_i(1'h0),
        .log_wrap_enable_i(1'h0), .wake_i(wake), .delay_done_i(ddone), .alarm_hit_i(alarm),
        .temp_sample_i(16'hABCD), .humid_sample_i(16'h1234), .mission_active_o(act), .mem_cleared_o(mcl),
        .waiting_alarm_o(wta), .mission_sample_count_o(mcnt), .lifetime_sample_count_o(lcnt), .log_we_o(),
        .log_addr_o(laddr), .log_data_o());
    mlpc_monitor mlpc_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .cmd_code(link.cmd_code),
        .cmd_valid(link.cmd_valid), .pw_valid(link.pw_valid), .done(link.done), .ok(link.ok), .rdata(link.rdata));

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp)
            miscompares++;
    endtask

    // One classic cycle; the request stands until ack is seen at a rising edge.
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do @(posedge clk_i); while (ack !== 1'h1);
        st = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        sel <= 4'h0;
    endtask

    // Loads the password, issues the command and polls until busy drops; st keeps the status.
    task automatic cmd(input logic [2:0] c, input logic [9:0] a, input logic [7:0] d, input logic [63:0] pw);
        wb(1'h1, mlpc_pkg::WB_PW_LO, pw[31:0]);
        wb(1'h1, mlpc_pkg::WB_PW_HI, pw[63:32]);
        wb(1'h1, mlpc_pkg::WB_CMD, {6'h00, a, d, 5'h00, c});
        do wb(1'h0, mlpc_pkg::WB_STATUS, 32'h0); while (st[0] !== 1'h0);
    endtask

    task automatic pulse(input logic al);
        @(posedge clk_i);
        wake <= 1'h1;
        alarm <= al;
        @(posedge clk_i);
        wake <= 1'h0;
        repeat (3) @(posedge clk_i);
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            $display("mismatch at %0t: timeout", $time);
            wrap_up();
        end
    end

    initial
    begin
        {cyc, stb, we, adr, sel, wdat, sut, ten, hen, twide, wake, ddone, alarm} = '0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        cmd(3'h3, 10'h226, 8'h00, BAD);
        chk(st[1], 1'h1);
        chk(st[15:8], mlpc_pkg::VARIANT_CODE);
        cmd(3'h2, 10'h000, 8'h00, BAD);
        chk(lcnt, 24'h000001);
        $display("test basics done");
        for (int i = 7; i < 24; i++)
            cmd(3'h0, 10'h220 + 10'(i), i == 7 ? 8'hAA : i < 16 ? RPW[8*(i-8) +: 8] : FPW[8*(i-16) +: 8], BAD);
        cmd(3'h1, 10'h227, 8'h00, BAD);
        chk(st[15:8], 8'hAA);
        cmd(3'h4, 10'h220, 8'h00, BAD);
        chk(st[1], 1'h1);
        cmd(3'h3, 10'h227, 8'h00, BAD);
        chk(st[1], 1'h0);
        cmd(3'h3, 10'h227, 8'h00, RPW);
        chk(st[15:8], 8'hAA);
        cmd(3'h4, 10'h220, 8'h00, RPW);
        chk(st[1], 1'h0);
        cmd(3'h3, 10'h230, 8'h00, FPW);
        chk(st[15:8], 8'h00);
        cmd(3'h5, 10'h000, 8'h00, RPW);
        chk(st[1], 1'h0);
        cmd(3'h5, 10'h000, 8'h00, FPW);
        chk(mcnt, 24'h000000);
        $display("test passwords done");
        ten <= 1'h1;
        hen <= 1'h1;
        ddone <= 1'h1;
        cmd(3'h6, 10'h000, 8'h00, FPW);
        chk(act, 1'h1);
        repeat (3) pulse(1'h0);
        chk(mcnt, 24'h000003);
        chk(lcnt, 24'h000004);
        chk(laddr[1], 13'h1002);
        cmd(3'h4, 10'h220, 8'h00, FPW);
        chk(st[1], 1'h0);
        cmd(3'h7, 10'h000, 8'h00, FPW);
        chk(act, 1'h0);
        cmd(3'h5, 10'h000, 8'h00, FPW);
        chk(mcnt, 24'h000000);
        chk(mcl, 1'h1);
        sut <= 1'h1;
        twide <= 1'h1;
        ddone <= 1'h0;
        cmd(3'h6, 10'h000, 8'h00, FPW);
        pulse(1'h1);
        chk(lcnt, 24'h000004);
        ddone <= 1'h1;
        pulse(1'h0);
        chk(lcnt, 24'h000005);
        chk(wta, 1'h1);
        pulse(1'h1);
        chk(mcnt, 24'h000000);
        chk(wta, 1'h0);
        pulse(1'h0);
        chk(mcnt, 24'h000001);
        chk(laddr[0], 13'h0002);
        chk(laddr[1], 13'h1401);
        $display("test missions done");
        wrap_up();
    end
endmodule
`default_nettype wire
